// file: core/occ_ctrl.sv
// Output compare channel: timebase, compare modes, PWM, fault override, registers
//
// Behaviour
// - Mode 111 makes center-aligned PWM, mode 110 edge-aligned PWM.
// - Mode 101 starts low, toggles on primary then secondary match, repeating.
// - Mode 100 starts low, primary match raises, secondary match lowers, one pulse.
// - Mode 011 toggles the output on every primary compare match.
// - Mode 010 starts high; first match drives low permanently.
// - Mode 001 starts low; first match drives high permanently.
// - Mode 000 disables all compare activity.
// - Exit select 1: in mode 111 fault holds until source gone and status cleared by software; in mode 110 only until source gone.
// - Exit select 0: fault holds until source gone and new period starts.
// - During fault the output is forced to the fault drive level.
// - Fault force direction 1 makes the pin an output during fault.
// - Output invert flips the channel output before the pin.
// - Subcycle delay code delays the falling edge by quarters of a cycle.
// - Inverted, the delay acts on rising edge; mode 001 ignores it.
// - Cascade joins two channels into one 32-bit compare unit.
// - Trigger select 1 starts timebase on trigger, 0 synchronises to source.
// - Trigger status reads 1 when triggered and running, 0 while held.
// - Pin tristate 1 releases the pin, 0 lets compare output drive it.
// - Source select: 0 none, 01011-01111 timers, 00001-00101 compare channels.
// - Trigger clear mode 1 clears status when timer equals secondary value.
// - Fault status flags are set on fault in mode 111 only.
// - New PWM compare values take effect only at period end or on a mode change.
`timescale 1ns/1ns
module occ_ctrl
   import occ_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic [OCC_AW-1:0] ADDR,
   input wire logic [OCC_DW-1:0] WDATA,
   input wire logic WR_STB,
   input wire logic RD_STB,
   output logic [OCC_DW-1:0] RDATA,
   input wire logic [31:0] SRC_EVT,
   input wire logic FAULT_IN,
   output occ_pin_s PIN_OUT
);

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [31:0] occ_fit(input logic [31:0] v, input logic casc);
      occ_fit = casc ? v : {16'h0000, v[15:0]};
   endfunction

   function automatic logic occ_sync_ok(input logic [4:0] c);
      occ_sync_ok = (c >= OCC_SRC_OC_FIRST && c <= OCC_SRC_OC_LAST)
                    || (c >= OCC_SRC_TMR_FIRST && c <= OCC_SRC_TMR_LAST);
   endfunction

   function automatic logic occ_trig_ok(input logic [4:0] c);
      occ_trig_ok = occ_sync_ok(c) || c == OCC_SRC_CAP5
                    || (c >= OCC_SRC_TRIG_FIRST && c <= OCC_SRC_TRIG_LAST);
   endfunction

   occ_state_s st_r;
   occ_state_s st_nxt;

   logic wr_c1;
   logic wr_c2;
   logic evt;
   logic trig_evt;
   logic sync_evt;
   logic pwm;
   logic running;
   logic match_p;
   logic match_s;
   logic tmr_top;
   logic period_end;
   logic mode_load;
   logic [31:0] tmr_max;
   logic [31:0] sec_fit;

   assign RDATA = st_r.rdata;
   assign PIN_OUT = st_r.pin;

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb
   begin
      st_nxt = st_r;
      wr_c1 = WR_STB && ADDR == OCC_REG_CTRL1;
      wr_c2 = WR_STB && ADDR == OCC_REG_CTRL2;
      evt = SRC_EVT[st_r.src];
      // Reserved codes fail both checks, so they act as no source
      trig_evt = st_r.trig_sel && occ_trig_ok(st_r.src) && evt;
      sync_evt = !st_r.trig_sel && occ_sync_ok(st_r.src) && evt;
      pwm = st_r.mode == OCC_M_PWM_EDGE || st_r.mode == OCC_M_PWM_CTR;
      running = st_r.mode != OCC_M_OFF && (!st_r.trig_sel || st_r.trig_stat);
      tmr_max = st_r.casc ? 32'hFFFFFFFF : 32'h0000FFFF;
      sec_fit = occ_fit(st_r.sec, st_r.casc);
      match_p = running && st_r.tmr == occ_fit(st_r.pri, st_r.casc);
      match_s = running && st_r.tmr == sec_fit;
      tmr_top = st_r.tmr >= tmr_max;
      if (st_r.mode == OCC_M_PWM_EDGE)
      begin
         period_end = running && st_r.tmr >= st_r.act_sec;
      end
      else
      begin
         period_end = running && (sync_evt || tmr_top);
      end
      mode_load = wr_c1 && WDATA[OCC_C1_MODE_LSB +: 3] != st_r.mode;

      // Read data stand for one cycle only
      st_nxt.rdata = 16'h0000;
      if (RD_STB)
      begin
         case (ADDR)
            OCC_REG_CTRL1: st_nxt.rdata = {11'h000, st_r.flt_stat, st_r.trig_clr, st_r.mode};
            OCC_REG_CTRL2: st_nxt.rdata = {st_r.exit_sel, st_r.flt_lvl, st_r.flt_dir, st_r.inv, 1'b0,
                                           st_r.dly, st_r.casc, st_r.trig_sel, st_r.trig_stat,
                                           st_r.tris, st_r.src};
            OCC_REG_PRI_LO: st_nxt.rdata = st_r.pri[15:0];
            OCC_REG_SEC_LO: st_nxt.rdata = st_r.sec[15:0];
            OCC_REG_PRI_HI: st_nxt.rdata = st_r.pri[31:16];
            OCC_REG_SEC_HI: st_nxt.rdata = st_r.sec[31:16];
            OCC_REG_TMR_LO: st_nxt.rdata = st_r.tmr[15:0];
            OCC_REG_TMR_HI: st_nxt.rdata = st_r.tmr[31:16];
            default: st_nxt.rdata = 16'h0000;
         endcase
      end

      // Register writes
      if (wr_c1)
      begin
         st_nxt.mode = occ_mode_e'(WDATA[OCC_C1_MODE_LSB +: 3]);
         st_nxt.trig_clr = WDATA[OCC_C1_TRIGCLR_BIT];
         // Writing one leaves the status alone; only a zero clears it
         if (!WDATA[OCC_C1_FLTSTAT_BIT])
         begin
            st_nxt.flt_stat = 1'b0;
         end
      end
      if (wr_c2)
      begin
         st_nxt.exit_sel = WDATA[OCC_C2_EXIT_BIT];
         st_nxt.flt_lvl = WDATA[OCC_C2_FLTLVL_BIT];
         st_nxt.flt_dir = WDATA[OCC_C2_FLTDIR_BIT];
         st_nxt.inv = WDATA[OCC_C2_INV_BIT];
         st_nxt.dly = WDATA[OCC_C2_DLY_LSB +: 2];
         st_nxt.casc = WDATA[OCC_C2_CASC_BIT];
         st_nxt.trig_sel = WDATA[OCC_C2_TRIGSEL_BIT];
         st_nxt.trig_stat = WDATA[OCC_C2_TRIGGER_STATUS_BIT];
         st_nxt.tris = WDATA[OCC_C2_TRIS_BIT];
         st_nxt.src = WDATA[OCC_C2_SRC_LSB +: 5];
      end
      if (WR_STB && ADDR == OCC_REG_PRI_LO)
      begin
         st_nxt.pri[15:0] = WDATA;
      end
      if (WR_STB && ADDR == OCC_REG_SEC_LO)
      begin
         st_nxt.sec[15:0] = WDATA;
      end
      if (WR_STB && ADDR == OCC_REG_PRI_HI)
      begin
         st_nxt.pri[31:16] = WDATA;
      end
      if (WR_STB && ADDR == OCC_REG_SEC_HI)
      begin
         st_nxt.sec[31:16] = WDATA;
      end

      // Trigger status: hardware set beats any clear in the same cycle
      if (st_r.trig_clr && st_r.tmr == sec_fit)
      begin
         st_nxt.trig_stat = 1'b0;
      end
      if (trig_evt)
      begin
         st_nxt.trig_stat = 1'b1;
      end

      // Timebase
      if (!running)
      begin
         st_nxt.tmr = 32'h00000000;
      end
      else if (sync_evt || tmr_top || (st_r.mode == OCC_M_PWM_EDGE && period_end))
      begin
         st_nxt.tmr = 32'h00000000;
      end
      else
      begin
         st_nxt.tmr = st_r.tmr + 32'h00000001;
      end

      // Compare actions
      case (st_r.mode)
         OCC_M_OFF:
         begin
            st_nxt.out = 1'b0;
         end
         OCC_M_SS_HI:
         begin
            if (match_p)
            begin
               st_nxt.out = 1'b1;
            end
         end
         OCC_M_SS_LO:
         begin
            if (match_p)
            begin
               st_nxt.out = 1'b0;
            end
         end
         OCC_M_TOGGLE:
         begin
            if (match_p)
            begin
               st_nxt.out = !st_r.out;
            end
         end
         OCC_M_DUAL_ONE:
         begin
            if (!st_r.shot_done && match_p && !st_r.out)
            begin
               st_nxt.out = 1'b1;
            end
            else if (!st_r.shot_done && match_s && st_r.out)
            begin
               st_nxt.out = 1'b0;
               st_nxt.shot_done = 1'b1;
            end
         end
         OCC_M_DUAL_CONT:
         begin
            if (match_p && !st_r.out)
            begin
               st_nxt.out = 1'b1;
            end
            else if (match_s && st_r.out)
            begin
               st_nxt.out = 1'b0;
            end
         end
         OCC_M_PWM_EDGE:
         begin
            st_nxt.out = running && st_r.tmr < st_r.act_pri;
         end
         OCC_M_PWM_CTR:
         begin
            st_nxt.out = running && st_r.tmr >= st_r.act_pri && st_r.tmr < st_r.act_sec;
         end
         default:
         begin
            st_nxt.out = st_r.out;
         end
      endcase

      // Double buffer: duty and delay only change at a period boundary or on a mode change
      if ((pwm && period_end) || mode_load)
      begin
         st_nxt.act_pri = occ_fit(st_nxt.pri, st_nxt.casc);
         st_nxt.act_sec = occ_fit(st_nxt.sec, st_nxt.casc);
         st_nxt.act_dly = st_nxt.dly;
      end

      // Fault override, PWM modes only
      if (pwm)
      begin
         if (FAULT_IN)
         begin
            st_nxt.flt_act = 1'b1;
            if (st_r.mode == OCC_M_PWM_CTR)
            begin
               st_nxt.flt_stat = 1'b1;
            end
         end
         else if (st_r.flt_act)
         begin
            if (st_r.exit_sel)
            begin
               st_nxt.flt_act = st_nxt.flt_stat;
            end
            else
            begin
               st_nxt.flt_act = !period_end;
            end
         end
      end
      else
      begin
         st_nxt.flt_act = 1'b0;
      end

      // A new mode starts from its documented initial level
      if (mode_load)
      begin
         st_nxt.tmr = 32'h00000000;
         st_nxt.out = st_nxt.mode == OCC_M_SS_LO;
         st_nxt.shot_done = 1'b0;
         st_nxt.flt_act = 1'b0;
      end

      // Pin stage
      if (st_nxt.flt_act)
      begin
         st_nxt.pin.out = st_nxt.flt_lvl;
      end
      else
      begin
         st_nxt.pin.out = st_nxt.out ^ st_nxt.inv;
      end
      st_nxt.pin.oe = !st_nxt.tris || (st_nxt.flt_act && st_nxt.flt_dir);
      // Phase qualifies the edge of the logical output; inverted, that is the pin's rising edge
      st_nxt.pin.phase = 2'h0;
      if (st_r.out && !st_nxt.out && !st_nxt.flt_act && st_r.mode != OCC_M_SS_HI)
      begin
         st_nxt.pin.phase = pwm ? st_r.act_dly : st_r.dly;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         st_r <= '0;
         st_r.mode <= OCC_M_OFF;
         st_r.src <= OCC_C2_RST[OCC_C2_SRC_LSB +: 5];
         st_r.pin.oe <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking occ_cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RST);

   AST_OFF_HELD: assert property ((st_r.mode == OCC_M_OFF) |-> (st_r.tmr == 32'h0 && !st_r.out))
      else $error("Disabled channel shows activity");
   AST_SS_HI_STAYS: assert property ((st_r.mode == OCC_M_SS_HI && st_r.out && !wr_c1) |=> st_r.out)
      else $error("Single shot high output fell");
   AST_SS_LO_STAYS: assert property ((st_r.mode == OCC_M_SS_LO && !st_r.out && !wr_c1) |=> !st_r.out)
      else $error("Single shot low output rose");
   AST_TOGGLE: assert property ((st_r.mode == OCC_M_TOGGLE && match_p && !wr_c1)
                                |=> st_r.out != $past(st_r.out))
      else $error("Toggle mode missed a match");
   AST_PWM_EDGE: assert property ((st_r.mode == OCC_M_PWM_EDGE && running && !wr_c1)
                                  |=> st_r.out == ($past(st_r.tmr) < $past(st_r.act_pri)))
      else $error("Edge PWM level wrong");
   AST_FAULT_LVL: assert property (st_r.flt_act |-> PIN_OUT.out == st_r.flt_lvl)
      else $error("Fault level not driven");
   AST_TRIS: assert property ((st_r.tris && !st_r.flt_act) |-> !PIN_OUT.oe)
      else $error("Tristated pin driven");
   AST_TRIG_SET: assert property ((trig_evt && !wr_c2) |=> st_r.trig_stat)
      else $error("Trigger did not set status");
   AST_TRIG_HOLD: assert property ((st_r.trig_sel && !st_r.trig_stat) [*2] |-> st_r.tmr == 32'h0)
      else $error("Timer ran before trigger");
   AST_FLT_STICKY: assert property ((st_r.flt_act && st_r.exit_sel && st_r.flt_stat && pwm && !wr_c1)
                                    |=> st_r.flt_act)
      else $error("Fault released before status cleared");
   AST_RELOAD: assert property ((pwm && !period_end && !mode_load) |=> $stable(st_r.act_pri))
      else $error("Duty changed mid period");

   COV_PWM_PULSE: cover property (st_r.mode == OCC_M_PWM_EDGE && $rose(PIN_OUT.out) ##[1:50] $fell(PIN_OUT.out));
   COV_FAULT: cover property (st_r.mode == OCC_M_PWM_CTR && $rose(st_r.flt_act) ##[1:50] $fell(st_r.flt_act));
   COV_TRIGGER: cover property ($rose(st_r.trig_stat) ##[1:50] $fell(st_r.trig_stat));
   COV_ONE_SHOT: cover property ($rose(st_r.shot_done));

endmodule

// file: core/occ_pkg.sv
// Constants, field layouts and carrier types of the output compare channel
package occ_pkg;

   // ************************************************************
   // Register bus
   // ************************************************************
   localparam int OCC_AW = 3;
   localparam int OCC_DW = 16;

   localparam logic [2:0] OCC_REG_CTRL1 = 3'h0;
   localparam logic [2:0] OCC_REG_CTRL2 = 3'h1;
   localparam logic [2:0] OCC_REG_PRI_LO = 3'h2;
   localparam logic [2:0] OCC_REG_SEC_LO = 3'h3;
   localparam logic [2:0] OCC_REG_PRI_HI = 3'h4;
   localparam logic [2:0] OCC_REG_SEC_HI = 3'h5;
   localparam logic [2:0] OCC_REG_TMR_LO = 3'h6;
   localparam logic [2:0] OCC_REG_TMR_HI = 3'h7;

   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int OCC_C1_MODE_LSB = 0;
   localparam int OCC_C1_TRIGCLR_BIT = 3;
   localparam int OCC_C1_FLTSTAT_BIT = 4;

   localparam int OCC_C2_EXIT_BIT = 15;
   localparam int OCC_C2_FLTLVL_BIT = 14;
   localparam int OCC_C2_FLTDIR_BIT = 13;
   localparam int OCC_C2_INV_BIT = 12;
   localparam int OCC_C2_DLY_LSB = 9;
   localparam int OCC_C2_CASC_BIT = 8;
   localparam int OCC_C2_TRIGSEL_BIT = 7;
   localparam int OCC_C2_TRIGGER_STATUS_BIT = 6;
   localparam int OCC_C2_TRIS_BIT = 5;
   localparam int OCC_C2_SRC_LSB = 0;

   localparam logic [15:0] OCC_C1_RST = 16'h0000;
   localparam logic [15:0] OCC_C2_RST = 16'h000C;

   // ************************************************************
   // Source select codes
   // ************************************************************
   localparam logic [4:0] OCC_SRC_NONE = 5'h00;
   localparam logic [4:0] OCC_SRC_OC_FIRST = 5'h01;
   localparam logic [4:0] OCC_SRC_OC_LAST = 5'h05;
   localparam logic [4:0] OCC_SRC_CAP5 = 5'h0A;
   localparam logic [4:0] OCC_SRC_TMR_FIRST = 5'h0B;
   localparam logic [4:0] OCC_SRC_TMR_LAST = 5'h0F;
   localparam logic [4:0] OCC_SRC_TRIG_FIRST = 5'h14;
   localparam logic [4:0] OCC_SRC_TRIG_LAST = 5'h1C;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [2:0] {
      OCC_M_OFF,
      OCC_M_SS_HI,
      OCC_M_SS_LO,
      OCC_M_TOGGLE,
      OCC_M_DUAL_ONE,
      OCC_M_DUAL_CONT,
      OCC_M_PWM_EDGE,
      OCC_M_PWM_CTR
   } occ_mode_e;

   typedef struct packed {
      logic out;
      logic oe;
      logic [1:0] phase;
   } occ_pin_s;

   typedef struct packed {
      occ_mode_e mode;
      logic trig_clr;
      logic flt_stat;
      logic exit_sel;
      logic flt_lvl;
      logic flt_dir;
      logic inv;
      logic [1:0] dly;
      logic casc;
      logic trig_sel;
      logic trig_stat;
      logic tris;
      logic [4:0] src;
      logic [31:0] pri;
      logic [31:0] sec;
      logic [31:0] act_pri;
      logic [31:0] act_sec;
      logic [1:0] act_dly;
      logic [31:0] tmr;
      logic out;
      logic shot_done;
      logic flt_act;
      occ_pin_s pin;
      logic [15:0] rdata;
   } occ_state_s;

endpackage

// file: tb/occ_load.sv
// External load on the compare pin: resolves the wire and logs edge phase
`timescale 1ns/1ns
module occ_load
   import occ_pkg::*;
#(
   parameter logic PULL = 1'b1
)
(
   input wire logic clk,
   input wire logic rst,
   input wire occ_pin_s pin,
   output logic level,
   output logic [1:0] last_phase
);
   // Weak pull makes a released pin visible, never a stale level
   assign level = pin.oe ? pin.out : PULL;

   // Sub-cycle edge position, kept after the one-cycle code has gone
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         last_phase <= 2'h0;
      end
      else if (pin.phase != 2'h0)
      begin
         last_phase <= pin.phase;
      end
   end
endmodule

// file: tb/tb.sv
// Self-checking bench for the output compare channel
`timescale 1ns/1ns
module tb;
   import occ_pkg::*;
   logic SYS_CLK = 1'b0;
   logic RST = 1'b1;
   logic [OCC_AW-1:0] ADDR = '0;
   logic [OCC_DW-1:0] WDATA = '0;
   logic WR_STB = 1'b0;
   logic RD_STB = 1'b0;
   logic [OCC_DW-1:0] RDATA;
   logic [31:0] SRC_EVT = '0;
   logic FAULT_IN = 1'b0;
   occ_pin_s PIN_OUT;
   logic level;
   logic [1:0] last_phase;
   logic [15:0] rv;
   logic sync_on = 1'b0;
   logic trig_req = 1'b0;
   int errors = 0;
   int tests_run = 0;
   int cyc = 0;
   int hi;
   // Pin level at 4, 12 and 24 cycles for modes 1 to 5
   logic [2:0] exp_tbl [1:5] = '{3'b011, 3'b100, 3'b011, 3'b010, 3'b010};

   always #2 SYS_CLK = ~SYS_CLK;

   occ_ctrl u_dut (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB),
      .RD_STB(RD_STB), .RDATA(RDATA), .SRC_EVT(SRC_EVT), .FAULT_IN(FAULT_IN), .PIN_OUT(PIN_OUT));
   occ_load u_load (.clk(SYS_CLK), .rst(RST), .pin(PIN_OUT), .level(level), .last_phase(last_phase));

   // Timer-1 sync every 20 cycles; timer-2 trigger on request
   always @(posedge SYS_CLK)
   begin
      cyc <= cyc + 1;
      SRC_EVT <= {19'h0, trig_req, sync_on && (cyc % 20 == 0), 11'h0};
      if (cyc == 5000)
      begin
         errors = errors + 1;
         test_done();
      end
   end

   // ********************
   // Bus and check tasks
   // ********************
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge SYS_CLK);
      ADDR <= a;
      WDATA <= d;
      WR_STB <= 1'b1;
      @(posedge SYS_CLK);
      WR_STB <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a);
      @(posedge SYS_CLK);
      ADDR <= a;
      RD_STB <= 1'b1;
      @(posedge SYS_CLK);
      RD_STB <= 1'b0;
      #1;
      rv = RDATA;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge SYS_CLK);
      #1;
   endtask

   // High cycles of the pin output over a window
   task automatic count_hi(input int n);
      hi = 0;
      repeat (n)
      begin
         @(posedge SYS_CLK);
         #1;
         if (PIN_OUT.out === 1'b1)
            hi++;
      end
   endtask

   task automatic test_done();
      if (errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ********************
   // Test sequence
   // ********************
   initial
   begin
      repeat (16) @(posedge SYS_CLK);
      RST <= 1'b0;
      rd(OCC_REG_CTRL1);
      chk(rv, 16'h0000);
      rd(OCC_REG_CTRL2);
      chk(rv, 16'h000C);
      chk({14'h0, PIN_OUT.out, PIN_OUT.oe}, 16'h0001);
      wr(OCC_REG_CTRL2, 16'hFFE0);
      rd(OCC_REG_CTRL2);
      chk(rv, 16'hF7E0);
      wr(OCC_REG_CTRL2, 16'h0000);
      wr(OCC_REG_TMR_LO, 16'hFFFF);
      rd(OCC_REG_TMR_LO);
      chk(rv, 16'h0000);
      // Single and double compare modes, primary 8, secondary 16
      wr(OCC_REG_PRI_LO, 16'h0008);
      wr(OCC_REG_SEC_LO, 16'h0010);
      for (int m = 1; m <= 5; m++)
      begin
         wr(OCC_REG_CTRL1, 16'(m));
         for (int t = 2; t >= 0; t--)
         begin
            wt(t == 2 ? 4 : (t == 1 ? 8 : 12));
            chk(16'(level), 16'(exp_tbl[m][t]));
         end
      end
      wr(OCC_REG_CTRL1, 16'h0000);
      wt(20);
      chk(16'(level), 16'h0000);
      rd(OCC_REG_TMR_LO);
      chk(rv, 16'h0000);
      wr(OCC_REG_CTRL2, 16'h1000);
      wr(OCC_REG_CTRL1, 16'h0001);
      wt(4);
      chk(16'(level), 16'h0001);
      wt(8);
      chk(16'(level), 16'h0000);
      wr(OCC_REG_CTRL2, 16'h0400);
      wr(OCC_REG_CTRL1, 16'h0002);
      wt(16);
      chk(16'(last_phase), 16'h0002);
      // Same mode again would not reload, so pass through off first
      wr(OCC_REG_CTRL1, 16'h0000);
      wr(OCC_REG_CTRL2, 16'h1600);
      wr(OCC_REG_CTRL1, 16'h0002);
      wt(16);
      chk(16'(last_phase), 16'h0003);
      wr(OCC_REG_CTRL2, 16'h0020);
      wt(2);
      chk({15'h0, PIN_OUT.oe}, 16'h0000);
      chk(16'(level), 16'h0001);
      // Cascade: 0x0001_0000 is out of reach, low half alone is not
      wr(OCC_REG_PRI_HI, 16'h0001);
      wr(OCC_REG_PRI_LO, 16'h0000);
      wr(OCC_REG_CTRL2, 16'h0100);
      wr(OCC_REG_CTRL1, 16'h0001);
      wt(30);
      chk(16'(level), 16'h0000);
      wr(OCC_REG_CTRL1, 16'h0000);
      wr(OCC_REG_CTRL2, 16'h0000);
      wr(OCC_REG_CTRL1, 16'h0001);
      wt(10);
      chk(16'(level), 16'h0001);
      wr(OCC_REG_PRI_HI, 16'h0000);
      wr(OCC_REG_PRI_LO, 16'h0003);
      wr(OCC_REG_SEC_LO, 16'h0009);
      wr(OCC_REG_CTRL1, 16'h0006);
      wt(20);
      count_hi(100);
      chk(16'(hi), 16'd30);
      wr(OCC_REG_PRI_LO, 16'h0005);
      wt(12);
      count_hi(100);
      chk(16'(hi), 16'd50);
      wr(OCC_REG_PRI_LO, 16'h0004);
      wr(OCC_REG_SEC_LO, 16'h000A);
      wr(OCC_REG_CTRL2, 16'h000B);
      sync_on <= 1'b1;
      wr(OCC_REG_CTRL1, 16'h0007);
      wt(40);
      count_hi(100);
      chk(16'(hi), 16'd30);
      // Fault held until status cleared, driven high, pin forced out
      wr(OCC_REG_CTRL2, 16'hE02B);
      @(posedge SYS_CLK);
      FAULT_IN <= 1'b1;
      wt(4);
      chk({14'h0, PIN_OUT.out, PIN_OUT.oe}, 16'h0003);
      rd(OCC_REG_CTRL1);
      chk(rv, 16'h0017);
      @(posedge SYS_CLK);
      FAULT_IN <= 1'b0;
      count_hi(40);
      chk(16'(hi), 16'd40);
      wr(OCC_REG_CTRL2, 16'hE00B);
      wr(OCC_REG_CTRL1, 16'h0007);
      wt(40);
      count_hi(100);
      chk(16'(hi), 16'd30);
      // Fault ends with the period, driven low, direction untouched
      wr(OCC_REG_CTRL2, 16'h002B);
      @(posedge SYS_CLK);
      FAULT_IN <= 1'b1;
      count_hi(40);
      chk(16'(hi), 16'd0);
      chk({15'h0, PIN_OUT.oe}, 16'h0000);
      @(posedge SYS_CLK);
      FAULT_IN <= 1'b0;
      wt(25);
      count_hi(100);
      chk(16'(hi), 16'd30);
      // Trigger mode: held, started by timer 2, cleared at secondary
      sync_on <= 1'b0;
      wr(OCC_REG_CTRL1, 16'h0000);
      wr(OCC_REG_PRI_LO, 16'h0008);
      wr(OCC_REG_SEC_LO, 16'h001E);
      wr(OCC_REG_CTRL2, 16'h008C);
      wr(OCC_REG_CTRL1, 16'h0009);
      wt(20);
      rd(OCC_REG_TMR_LO);
      chk(rv, 16'h0000);
      rd(OCC_REG_CTRL2);
      chk(rv, 16'h008C);
      @(posedge SYS_CLK);
      trig_req <= 1'b1;
      @(posedge SYS_CLK);
      trig_req <= 1'b0;
      wt(4);
      rd(OCC_REG_CTRL2);
      chk(rv, 16'h00CC);
      wt(40);
      rd(OCC_REG_CTRL2);
      chk(rv, 16'h008C);
      rd(OCC_REG_TMR_LO);
      chk(rv, 16'h0000);
      chk(16'(level), 16'h0001);
      test_done();
   end
endmodule
